// file: irq_flag_stack_select.sv
// Interrupt enable flag, stack select flag and priority threshold of the core.
// Assumes all inputs come from logic on clk_i (sequencer and request arbiter).
//
// How it works
// RQ1 - Interrupt enable flag zero blocks maskable requests
// RQ2 - Acknowledge clears the interrupt enable flag
// RQ3 - Stack select zero trap pointer, one app
// RQ4 - Hardware acknowledge or trap 0..31 clears select
// RQ5 - Three-bit threshold; accept only higher priority
`timescale 1ns/1ps
`include "irq_gate_params.svh"

module irq_flag_stack_select
(
  // Clock, reset, enable
  input  wire logic                      clk_i,
  input  wire logic                      sys_rst_i,
  input  wire logic                      clk_en_i,
  // Flag writes from instructions
  input  wire logic                      i_flag_wr_i,
  input  wire logic                      i_flag_val_i,
  input  wire logic                      u_flag_wr_i,
  input  wire logic                      u_flag_val_i,
  input  wire logic                      level_wr_i,
  input  wire irq_gate_pkg::level_t      level_val_i,
  // Interrupt request and acknowledge
  input  wire logic                      irq_req_i,
  input  wire logic                      irq_maskable_i,
  input  wire irq_gate_pkg::level_t      irq_level_i,
  input  wire logic                      irq_ack_i,
  // Software trap execution
  input  wire logic                      trap_exec_i,
  input  wire irq_gate_pkg::trap_num_t   trap_num_i,
  // Stack pointers
  input  wire irq_gate_pkg::sp_t         trap_stack_pointer_i,
  input  wire irq_gate_pkg::sp_t         app_stack_pointer_i,
  // Outputs
  output wire logic                      irq_accept_o,
  output wire logic                      i_flag_o,
  output wire logic                      u_flag_o,
  output wire irq_gate_pkg::level_t      level_threshold_o,
  output wire irq_gate_pkg::sp_t         active_sp_o
);

  // ----------------------------------------
  // Flag state
  // ----------------------------------------
  logic                 i_flag_r;
  logic                 i_flag_nxt;
  logic                 u_flag_r;
  logic                 u_flag_nxt;
  irq_gate_pkg::level_t level_r;
  irq_gate_pkg::level_t level_nxt;
  irq_gate_pkg::sp_t    active_sp_r;
  irq_gate_pkg::sp_t    active_sp_nxt;

  wire above;
  wire low_trap;
  wire clear_u;

  // ----------------------------------------
  // Acceptance decision
  // ----------------------------------------
  level_compare u_cmp
  (
    .req_level_i       (irq_level_i),
    .level_threshold_i (level_r),
    .above_o           (above)
  );

  // Non-maskable requests ignore both the flag and the threshold
  assign irq_accept_o = irq_req_i & (~irq_maskable_i | (i_flag_r & above)); // [RQ1] [RQ5]

  // ----------------------------------------
  // Next-state decode
  // ----------------------------------------
  assign low_trap = trap_exec_i & (trap_num_i <= `LOW_TRAP_LAST);
  assign clear_u  = irq_ack_i | low_trap; // [RQ4]

  // Hardware clears take priority over an instruction write in the same cycle
  assign i_flag_nxt = irq_ack_i ? 1'h0 : (i_flag_wr_i ? i_flag_val_i : i_flag_r); // [RQ2]
  assign u_flag_nxt = clear_u ? 1'h0 : (u_flag_wr_i ? u_flag_val_i : u_flag_r); // [RQ4]
  assign level_nxt  = level_wr_i ? level_val_i : level_r; // [RQ5]
  assign active_sp_nxt = u_flag_nxt ? app_stack_pointer_i : trap_stack_pointer_i; // [RQ3]

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      i_flag_r    <= `RST_I_FLAG;
      u_flag_r    <= `RST_U_FLAG;
      level_r     <= `RST_LEVEL;
      active_sp_r <= '0;
    end
    else if (clk_en_i)
    begin
      i_flag_r    <= i_flag_nxt;
      u_flag_r    <= u_flag_nxt;
      level_r     <= level_nxt;
      active_sp_r <= active_sp_nxt;
    end
  end

  assign i_flag_o          = i_flag_r;
  assign u_flag_o          = u_flag_r;
  assign level_threshold_o = level_r;
  assign active_sp_o       = active_sp_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_mask_blocks: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ1]
    (irq_req_i && irq_maskable_i && !i_flag_r) |-> !irq_accept_o)
    else $error("maskable request accepted with enable flag low");

  a_ack_clears_i: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ2]
    (clk_en_i && irq_ack_i) |=> !i_flag_o)
    else $error("enable flag not cleared after acknowledge");

  a_sp_select: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ3]
    clk_en_i |=> active_sp_o ==
      (u_flag_o ? $past(app_stack_pointer_i) : $past(trap_stack_pointer_i)))
    else $error("active stack pointer does not follow select flag");

  a_trap_clears_u: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ4]
    (clk_en_i && trap_exec_i && trap_num_i < 6'h20) |=> !u_flag_o)
    else $error("select flag not cleared by low trap");

  a_high_trap_keeps: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ4]
    (clk_en_i && trap_exec_i && trap_num_i >= 6'h20 && !irq_ack_i && !u_flag_wr_i)
      |=> u_flag_o == $past(u_flag_o))
    else $error("select flag changed by high trap");

  a_level_gate: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ5]
    (irq_req_i && irq_maskable_i && i_flag_r)
      |-> irq_accept_o == (irq_level_i > level_threshold_o))
    else $error("priority comparison wrong");

  // ----------------------------------------
  // Reset, freeze, write, acceptance and clear checks
  // ----------------------------------------
  a_reset_clears_all: assert property (@(posedge clk_i) // [RQ1]
    sys_rst_i
      |=> (!i_flag_o && !u_flag_o && level_threshold_o == 3'h0 && active_sp_o == 16'h0000))
    else $error("flags not cleared by reset");

  a_nmi_passes: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ1]
    (irq_req_i && !irq_maskable_i)
      |-> irq_accept_o)
    else $error("non-maskable request not accepted");

  a_no_req_idle: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ1]
    !irq_req_i
      |-> !irq_accept_o)
    else $error("accept raised without a request");

  a_ack_beats_write: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ2]
    (clk_en_i && irq_ack_i && i_flag_wr_i && i_flag_val_i)
      |=> !i_flag_o)
    else $error("enable flag write won over acknowledge");

  a_i_write_lands: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ2]
    (clk_en_i && i_flag_wr_i && !irq_ack_i)
      |=> i_flag_o == $past(i_flag_val_i))
    else $error("enable flag write lost");

  a_i_holds: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ2]
    (clk_en_i && !i_flag_wr_i && !irq_ack_i)
      |=> i_flag_o == $past(i_flag_o))
    else $error("enable flag changed without cause");

  a_freeze_state: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ3]
    !clk_en_i
      |=> {i_flag_o, u_flag_o, level_threshold_o, active_sp_o} ==
          $past({i_flag_o, u_flag_o, level_threshold_o, active_sp_o}))
    else $error("state moved while clock enable low");

  a_sp_after_ack: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ3]
    (clk_en_i && irq_ack_i)
      |=> active_sp_o == $past(trap_stack_pointer_i))
    else $error("trap stack pointer not active after acknowledge");

  a_sp_app_side: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ3]
    (clk_en_i && u_flag_wr_i && u_flag_val_i && !irq_ack_i && !trap_exec_i)
      |=> active_sp_o == $past(app_stack_pointer_i))
    else $error("app stack pointer not active after select write");

  a_ack_clears_u: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ4]
    (clk_en_i && irq_ack_i)
      |=> !u_flag_o)
    else $error("select flag not cleared after acknowledge");

  a_trap_last_low: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ4]
    (clk_en_i && trap_exec_i && trap_num_i == 6'h1F)
      |=> !u_flag_o)
    else $error("select flag not cleared by highest low trap");

  a_u_write_lands: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ4]
    (clk_en_i && u_flag_wr_i && !irq_ack_i && !(trap_exec_i && trap_num_i < 6'h20))
      |=> u_flag_o == $past(u_flag_val_i))
    else $error("select flag write lost");

  a_level_write: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ5]
    (clk_en_i && level_wr_i)
      |=> level_threshold_o == $past(level_val_i))
    else $error("threshold write lost");

  a_level_holds: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ5]
    (clk_en_i && !level_wr_i)
      |=> level_threshold_o == $past(level_threshold_o))
    else $error("threshold changed without write");

  a_top_level_blocks: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ5]
    (irq_req_i && irq_maskable_i && level_threshold_o == 3'h7)
      |-> !irq_accept_o)
    else $error("maskable request accepted at top threshold");

endmodule

// file: irq_gate_params.svh
// Constants for the interrupt gate and stack select flag logic.
// Assumes inclusion by the package and the design files.
`ifndef IRQ_GATE_PARAMS_SVH
`define IRQ_GATE_PARAMS_SVH

// ----------------------------------------
// Widths, field positions and reset values
// ----------------------------------------
`define LEVEL_W          3
`define TRAP_NUM_W       6
`define SP_W             16
`define LOW_TRAP_LAST    6'h1F
`define FLAGS_I_BIT      0
`define FLAGS_U_BIT      1
`define RST_I_FLAG       1'h0
`define RST_U_FLAG       1'h0
`define RST_LEVEL        3'h0

`endif

// file: irq_gate_pkg.sv
// Types for the interrupt gate and stack select flag logic.
// Assumes irq_gate_params.svh is on the include path.
`include "irq_gate_params.svh"

package irq_gate_pkg;

  typedef logic [`LEVEL_W-1:0]    level_t;
  typedef logic [`TRAP_NUM_W-1:0] trap_num_t;
  typedef logic [`SP_W-1:0]       sp_t;

endpackage

// file: irq_source_model.sv
// Behavioural request source and sequencer facing the flag logic.
// Assumes the bench drives req_i and go_i just after falling clock edges.
`timescale 1ns/1ps

module irq_source_model
(
  // Request and sequencer readiness
  input  wire logic req_i,
  input  wire logic go_i,
  input  wire logic accept_i,
  // Acknowledge pulse back to the gate
  output wire logic ack_o
);
  // Acknowledge only a request that the gate let through
  assign ack_o = req_i & accept_i & go_i;
endmodule

// file: level_compare.sv
// Priority comparator: a request passes when its level beats the threshold.
// Assumes both inputs are on clk_i of the caller.
`timescale 1ns/1ps
`include "irq_gate_params.svh"

module level_compare
(
  // Levels
  input  wire irq_gate_pkg::level_t req_level_i,
  input  wire irq_gate_pkg::level_t level_threshold_i,
  // Result
  output wire logic                 above_o
);

  assign above_o = req_level_i > level_threshold_i; // [RQ5]

endmodule

// file: testbench.sv
// Random self-checking bench for the enable flag, stack select and threshold.
// Assumes irq_gate_pkg and irq_source_model are compiled before this file.
`timescale 1ns/1ps

module testbench;
  logic clk_i = 0, rst = 1, en = 1, iw = 0, iv = 0, uw = 0, uv = 0, lw = 0;
  logic req = 0, msk = 0, go = 0, trap = 0, acc, ack, ifo, ufo, ei, eu, ae;
  irq_gate_pkg::level_t lv = '0, rl = '0, el, thr;
  irq_gate_pkg::trap_num_t tn = '0;
  irq_gate_pkg::sp_t tsp = '0, asp = '0, sp, esp;
  logic [20:0] q[$];
  int bad_count = 0, checked = 0;

  always #4 clk_i = ~clk_i;

  irq_flag_stack_select i_irq_flag_stack_select
  (
    .clk_i(clk_i), .sys_rst_i(rst), .clk_en_i(en), .i_flag_wr_i(iw), .i_flag_val_i(iv),
    .u_flag_wr_i(uw), .u_flag_val_i(uv), .level_wr_i(lw), .level_val_i(lv),
    .irq_req_i(req), .irq_maskable_i(msk), .irq_level_i(rl), .irq_ack_i(ack),
    .trap_exec_i(trap), .trap_num_i(tn), .trap_stack_pointer_i(tsp),
    .app_stack_pointer_i(asp), .irq_accept_o(acc), .i_flag_o(ifo), .u_flag_o(ufo),
    .level_threshold_o(thr), .active_sp_o(sp)
  );

  irq_source_model i_irq_source_model
  (
    .req_i(req), .go_i(go), .accept_i(acc), .ack_o(ack)
  );

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic chk(input string nm, input logic [20:0] seen, input logic [20:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Registered outputs settle one step after the edge
  always @(posedge clk_i)
  begin
    #1;
    if (q.size() > 0)
      chk("flags", {ifo, ufo, thr, sp}, q.pop_front());
  end

  // ----------------------------------------
  // Stimulus and expected state
  // ----------------------------------------
  initial
  begin
    void'($urandom(32'h1f59_d1ce));
    ei = 1'b0;
    eu = 1'b0;
    el = 3'h0;
    esp = 16'h0000;
    repeat (6) @(negedge clk_i);
    rst = 0;
    repeat (3000)
    begin
      @(negedge clk_i);
      {iw, iv, uw, uv, lw, req, msk, go, trap} = 9'($urandom);
      lv = 3'($urandom);
      rl = 3'($urandom);
      tn = 6'($urandom);
      tsp = 16'($urandom);
      asp = 16'($urandom);
      rst = ($urandom_range(63) == 0);
      en = rst | ($urandom_range(7) != 0);
      ae = req & (!msk | (ei & (rl > el)));
      #1 chk("accept", {20'h0_0000, acc}, {20'h0_0000, ae});
      if (rst)
        {ei, eu, el, esp} = 21'h00_0000;
      else if (en)
      begin
        ei = (ae & go) ? 1'b0 : iw ? iv : ei;
        eu = ((ae & go) | (trap & (tn <= 6'h1F))) ? 1'b0 : uw ? uv : eu;
        el = lw ? lv : el;
        esp = eu ? asp : tsp;
      end
      q.push_back({ei, eu, el, esp});
    end
    @(negedge clk_i);
    finish_test();
  end
endmodule
